// [core/pal_cfg.svh]
// Constants of the peripheral access latency bridge.
// Included by bare name from the design files under core/.
`ifndef PAL_CFG_SVH
`define PAL_CFG_SVH

// Latency unit codes: core, fast peripheral, slow peripheral, flash.
`define PAL_U_CORE 2'h0
`define PAL_U_FAST 2'h1
`define PAL_U_SLOW 2'h2
`define PAL_U_FLSH 2'h3

// Region count and the indices that the control logic singles out.
`define PAL_NRGN 25
`define PAL_I_SYS0 5'h00
`define PAL_I_SEC 5'h01
`define PAL_I_SYS1 5'h02
`define PAL_I_SCI 5'h0F
`define PAL_I_SPI 5'h10
`define PAL_I_FLSH 5'h18

// Extra unit cycles of the wide serial registers.
`define PAL_EXTRA 8'h02
// Offset of the serial peripheral data word inside its region.
`define PAL_SPI_DATA_OFF 12'h004
// Answer time of an unmapped access, in core cycles.
`define PAL_LAT_UNMAP 8'h02
// Synchronisation allowance when the core runs faster.
`define PAL_SYNC 8'h01
// Counter value in the taking cycle, and its step per unit cycle.
`define PAL_CNT_START 8'h01
`define PAL_CNT_STEP 8'h01

// Entry: low, high, {unit, serial wait on read, on write},
// {equal read, equal write, faster read min, faster write min}.
`define PAL_R00 {32'h4000_0000,32'h4000_6FFF,4'h0,32'h0202_0202} // see RULE1
`define PAL_R01 {32'h4000_8000,32'h4001_CFFF,4'h0,32'h0403_0403} // see RULE2
`define PAL_R02 {32'h4001_E000,32'h4001_E3FF,4'h0,32'h0504_0504} // see RULE3
`define PAL_R03 {32'h4001_E400,32'h4001_E5FF,4'h8,32'h0908_0505} // see RULE4
`define PAL_R04 {32'h4008_0000,32'h4008_0FFF,4'h8,32'h0504_0202} // see RULE5
`define PAL_R05 {32'h4008_2000,32'h4008_3FFF,4'h8,32'h0504_0302} // see RULE6
`define PAL_R06 {32'h4008_4000,32'h4008_4FFF,4'h8,32'h0504_0202}
`define PAL_R07 {32'h4008_A000,32'h4008_AFFF,4'h8,32'h0504_0302}
`define PAL_R08 {32'h4009_0000,32'h4009_3FFF,4'h8,32'h0605_0303} // see RULE7
`define PAL_R09 {32'h4009_4000,32'h4009_4FFF,4'h8,32'h0403_0101} // see RULE8
`define PAL_R10 {32'h4009_2000,32'h4009_FFFF,4'h8,32'h0504_0202} // see RULE9
`define PAL_R11 {32'h400A_8000,32'h400A_9FFF,4'h8,32'h0504_0202}
`define PAL_R12 {32'h400E_0000,32'h400E_0FFF,4'h8,32'h0504_0202}
`define PAL_R13 {32'h400E_8000,32'h400E_8FFF,4'h8,32'h0704_0502} // see RULE10
`define PAL_R14 {32'h4010_8000,32'h4010_9FFF,4'h4,32'h0504_0202} // see RULE11
`define PAL_R15 {32'h4011_8000,32'h4011_8FFF,4'h4,32'h0504_0202}
`define PAL_R16 {32'h4011_A000,32'h4011_AFFF,4'h4,32'h0504_0202}
`define PAL_R17 {32'h4016_1000,32'h4016_1FFF,4'h4,32'h0604_0302} // see RULE14
`define PAL_R18 {32'h4016_9000,32'h4016_9FFF,4'h4,32'h0704_0402} // see RULE15
`define PAL_R19 {32'h4017_0000,32'h4017_2FFF,4'h4,32'h0504_0202} // see RULE16
`define PAL_R20 {32'h6400_0000,32'h6400_000F,4'h5,32'h050E_020E} // see RULE17
`define PAL_R21 {32'h6400_0010,32'h6400_0013,4'h7,32'h1906_1905} // see RULE18
`define PAL_R22 {32'h6400_0014,32'h6400_0037,4'h5,32'h050E_020E} // see RULE17
`define PAL_R23 {32'h6400_0804,32'h6400_0807,4'h4,32'h0403_0101} // see RULE19
`define PAL_R24 {32'h407F_C000,32'h407F_EFFF,4'hC,32'h0303_0202} // see RULE20

`endif

// [core/pal_pkg.sv]
// Types of the peripheral access latency bridge.
// Assumes nothing beyond a SystemVerilog compiler.
package pal_pkg;

    typedef enum logic [1:0] {
        PAL_SZ_BYTE = 2'b00,
        PAL_SZ_HALF = 2'b01,
        PAL_SZ_WORD = 2'b10
    } pal_size_type;

    typedef enum logic [1:0] {
        PAL_ST_IDLE = 2'b00,
        PAL_ST_COUNT = 2'b01,
        PAL_ST_SERIAL = 2'b10
    } pal_state_type;

    typedef struct packed {
        logic [31:0] lo;
        logic [31:0] hi;
        logic [1:0] unit;
        logic wait_rd;
        logic wait_wr;
        logic [7:0] eq_rd;
        logic [7:0] eq_wr;
        logic [7:0] min_rd;
        logic [7:0] min_wr;
    } pal_rgn_type;

endpackage : pal_pkg

// [core/pal_lat_if.sv]
`timescale 1ns/1ps
// Carrier between the bridge control and its region decoder.
// The control side drives the request, the decoder answers at once.
interface pal_lat_if;
    import pal_pkg::*;
    logic [31:0] addr;
    logic wr;
    pal_size_type size;
    logic [3:0] eq;
    logic [7:0] target;
    logic [1:0] unit;
    logic serial;
    logic hit;
    logic [4:0] idx;
    modport dec (input addr, wr, size, eq,
                 output target, unit, serial, hit, idx);
    modport ctl (output addr, wr, size, eq,
                 input target, unit, serial, hit, idx);
endinterface : pal_lat_if

// [core/pal_decode.sv]
`timescale 1ns/1ps
// Region decoder: maps an address onto its latency unit and count.
// Assumes the request attributes are stable in the taking cycle.
`include "pal_cfg.svh"
module pal_decode (
    // Request in, latency out
    pal_lat_if.dec lat
);
    import pal_pkg::*;

    localparam pal_rgn_type RGN [`PAL_NRGN] = '{
        `PAL_R00, `PAL_R01, `PAL_R02, `PAL_R03, `PAL_R04,
        `PAL_R05, `PAL_R06, `PAL_R07, `PAL_R08, `PAL_R09,
        `PAL_R10, `PAL_R11, `PAL_R12, `PAL_R13, `PAL_R14,
        `PAL_R15, `PAL_R16, `PAL_R17, `PAL_R18, `PAL_R19,
        `PAL_R20, `PAL_R21, `PAL_R22, `PAL_R23, `PAL_R24
    };

    logic [`PAL_NRGN-1:0] hit;
    pal_rgn_type sel;
    logic eq;
    logic extra;
    logic [7:0] base;

    genvar g;
    generate
        for (g = 0; g < `PAL_NRGN; g++) begin : g_rgn
            assign hit[g] = (lat.addr >= RGN[g].lo) &&
                            (lat.addr <= RGN[g].hi);
        end
    endgenerate

    // Lowest index wins, so the narrow USB windows shadow the wide
    // two-wire serial range that overlaps them.
    always_comb begin
        sel = '0;
        lat.idx = 5'h00;
        for (int i = `PAL_NRGN - 1; i >= 0; i--) begin
            if (hit[i]) begin
                sel = RGN[i];
                lat.idx = 5'(i);
            end
        end
    end

    assign lat.hit = |hit;
    assign eq = lat.eq[sel.unit];

    // Minimum figures are already whole unit cycles, fraction dropped.
    always_comb begin
        if (eq) begin
            base = lat.wr ? sel.eq_wr : sel.eq_rd; // see RULE21
        end else begin
            base = (lat.wr ? sel.min_wr : sel.min_rd) + `PAL_SYNC; // see RULE22
        end
    end

    assign extra = ((lat.idx == `PAL_I_SCI) &&
                    (lat.size == PAL_SZ_HALF)) || // see RULE12
                   ((lat.idx == `PAL_I_SPI) &&
                    (lat.size == PAL_SZ_WORD) &&
                    (lat.addr[11:0] == `PAL_SPI_DATA_OFF)); // see RULE13

    assign lat.target = !lat.hit ? `PAL_LAT_UNMAP :
                        extra ? base + `PAL_EXTRA : base;
    assign lat.unit = lat.hit ? sel.unit : `PAL_U_CORE;
    assign lat.serial = lat.wr ? sel.wait_wr : sel.wait_rd;

endmodule : pal_decode

// [core/pal_bridge.sv]
`timescale 1ns/1ps
// Peripheral access bridge: holds a master for each region's latency.
// Assumes the tick inputs mark peripheral clock edges in core cycles
// and are held high whenever that clock equals the core clock.
//
// Contract
// RULE1 - System-control low region: two core cycles
// RULE2 - Security/debug/cache: read four, write three
// RULE3 - Lower system control: read five, write four
// RULE4 - Upper system control counts slow peripheral cycles
// RULE5 - Port registers: slow clock, 5/4 or ranges
// RULE6 - Event, calendar, watchdog: slow clock figures
// RULE7 - Main USB region: slow clock figures
// RULE8 - Secondary USB region: slow clock figures
// RULE9 - Two-wire serial region: slow clock figures
// RULE10 - Low-power timer region: slow clock figures
// RULE11 - Checksum region: fast peripheral clock figures
// RULE12 - UART sixteen-bit registers add two cycles
// RULE13 - SPI full-word data access adds two
// RULE14 - Crypto region: fast peripheral clock figures
// RULE15 - PWM timer region: fast peripheral clock figures
// RULE16 - Converter region: fast peripheral clock figures
// RULE17 - Flash control writes wait serial activity
// RULE18 - Flash data window waits serial activity
// RULE19 - Flash register 0x804: fast clock figures
// RULE20 - Data flash region counts flash clocks
// RULE21 - Fractional bounds: floor minimum, ceil maximum
// RULE22 - Faster core adds one synchronisation cycle
// RULE23 - Master avoids reserved unallocated addresses
// RULE24 - Figures assume uncontended non-bufferable writes
// RULE25 - Hold master, then done with data
`include "pal_cfg.svh"
module pal_bridge (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Master request
    input wire logic i_req,
    input wire logic i_wr,
    input wire pal_pkg::pal_size_type i_size,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    // Master answer
    output logic o_ready,
    output logic o_done,
    output logic o_err,
    output logic [31:0] o_rdata,
    // Peripheral clock edges, one pulse per unit cycle
    input wire logic i_fast_tick,
    input wire logic i_slow_tick,
    input wire logic i_flash_tick,
    // High while that clock equals the core clock
    input wire logic i_fast_eq,
    input wire logic i_slow_eq,
    input wire logic i_flash_eq,
    // Serial flash bus has no cycle in progress
    input wire logic i_qspi_idle,
    // Peripheral side
    output logic o_per_sel,
    output logic o_per_wr,
    output pal_pkg::pal_size_type o_per_size,
    output logic [31:0] o_per_addr,
    output logic [31:0] o_per_wdata,
    input wire logic [31:0] i_per_rdata
);
    import pal_pkg::*;

    pal_lat_if lat ();

    pal_state_type state;
    pal_state_type next_state;
    logic [7:0] tgt;
    logic [1:0] unit;
    logic serial;
    logic hit_q;
    logic [7:0] cnt;
    logic tick;
    logic reached;
    logic take;
    logic fin;

    pal_decode u_decode (
        .lat(lat)
    );

    assign lat.addr = i_addr;
    assign lat.wr = i_wr;
    assign lat.size = i_size;
    // The core unit always counts as equal to itself.
    assign lat.eq = {i_flash_eq, i_slow_eq, i_fast_eq, 1'b1};

    // Only one access is in flight, which keeps the figures free of
    // contention; a second master simply waits on o_ready.
    assign o_ready = (state == PAL_ST_IDLE); // see RULE24
    assign take = i_req && o_ready;

    always_comb begin
        case (unit)
            `PAL_U_CORE: tick = 1'b1;
            `PAL_U_FAST: tick = i_fast_tick;
            `PAL_U_SLOW: tick = i_slow_tick;
            default: tick = i_flash_tick;
        endcase
    end

    // Whole unit cycles only: a partial peripheral cycle never counts.
    assign reached = (state == PAL_ST_COUNT) && tick &&
                     ((cnt + `PAL_CNT_STEP) >= tgt); // see RULE21

    // Serial flash accesses end no earlier than the count and no
    // earlier than the end of the serial bus cycle.
    assign fin = (reached && (!serial || i_qspi_idle)) ||
                 ((state == PAL_ST_SERIAL) && i_qspi_idle); // see RULE17

    always_comb begin
        next_state = state;
        case (state)
            PAL_ST_IDLE: begin
                if (take) begin
                    next_state = PAL_ST_COUNT;
                end
            end
            PAL_ST_COUNT: begin
                if (fin) begin
                    next_state = PAL_ST_IDLE;
                end else if (reached) begin
                    next_state = PAL_ST_SERIAL; // see RULE18
                end
            end
            PAL_ST_SERIAL: begin
                if (fin) begin
                    next_state = PAL_ST_IDLE;
                end
            end
            default: begin
                next_state = PAL_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= PAL_ST_IDLE;
        end else begin
            state <= next_state; // see RULE25
        end
    end

    // Region attributes are frozen at the taking edge.
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            tgt <= `PAL_LAT_UNMAP;
            unit <= `PAL_U_CORE;
            serial <= 1'b0;
            hit_q <= 1'b0;
        end else if (take) begin
            tgt <= lat.target; // see RULE4
            unit <= lat.unit; // see RULE20
            serial <= lat.serial;
            hit_q <= lat.hit;
        end
    end

    // The taking cycle is the first unit cycle of the access.
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt <= 8'h00;
        end else if (take) begin
            cnt <= `PAL_CNT_START;
        end else if ((state == PAL_ST_COUNT) && tick) begin
            cnt <= cnt + `PAL_CNT_STEP; // see RULE5
        end
    end

    // Reserved addresses never reach a peripheral select.
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_per_sel <= 1'b0;
            o_per_wr <= 1'b0;
            o_per_size <= PAL_SZ_BYTE;
            o_per_addr <= 32'h0000_0000;
            o_per_wdata <= 32'h0000_0000;
        end else if (take) begin
            o_per_sel <= lat.hit; // see RULE23
            o_per_wr <= i_wr;
            o_per_size <= i_size;
            o_per_addr <= i_addr;
            o_per_wdata <= i_wdata;
        end else if (fin) begin
            o_per_sel <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_done <= 1'b0;
            o_err <= 1'b0;
            o_rdata <= 32'h0000_0000;
        end else begin
            o_done <= fin; // see RULE25
            o_err <= fin && !hit_q;
            if (fin) begin
                o_rdata <= (hit_q && !o_per_wr) ? i_per_rdata :
                           32'h0000_0000;
            end
        end
    end

    // Core cycles since the taking edge, read only by the checks.
    logic [7:0] cyc;
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cyc <= 8'h00;
        end else if (take) begin
            cyc <= `PAL_CNT_START;
        end else if (state != PAL_ST_IDLE) begin
            cyc <= cyc + `PAL_CNT_STEP;
        end
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);

    sequence s_take(logic [4:0] idx, logic wr);
        take && lat.hit && (lat.idx == idx) && (i_wr == wr);
    endsequence

    sequence s_answer_after(int unsigned n);
        !o_done [*1] ##0 1'b1;
    endsequence

    property p_core_lat_rd(logic [4:0] idx);
        s_take(idx, 1'b0) |=> !o_done ##1 1'b1;
    endproperty

    a_sys_two_cycle: assert property ( // see RULE1
        s_take(`PAL_I_SYS0, i_wr) |=> !o_done ##1 o_done)
        else $error("low system region not answered in two cycles");

    a_sec_read_four: assert property ( // see RULE2
        s_take(`PAL_I_SEC, 1'b0) |=> !o_done [*3] ##1 o_done)
        else $error("security region read not four cycles");

    a_sec_write_three: assert property ( // see RULE2
        s_take(`PAL_I_SEC, 1'b1) |=> !o_done [*2] ##1 o_done)
        else $error("security region write not three cycles");

    a_sys_read_five: assert property ( // see RULE3
        s_take(`PAL_I_SYS1, 1'b0) |=> !o_done [*4] ##1 o_done)
        else $error("system control read not five cycles");

    a_sys_write_four: assert property ( // see RULE3
        s_take(`PAL_I_SYS1, 1'b1) |=> !o_done [*3] ##1 o_done)
        else $error("system control write not four cycles");

    a_flash_equal: assert property ( // see RULE20
        take && lat.hit && (lat.idx == `PAL_I_FLSH) && i_flash_eq
        |=> (tgt == 8'h03) && (unit == `PAL_U_FLSH))
        else $error("flash region equal-clock count not three");

    a_no_early_done: assert property ( // see RULE22
        o_done && !o_err |-> (cyc >= tgt))
        else $error("access completed before its latency");

    a_tick_gate: assert property ( // see RULE21
        (state == PAL_ST_COUNT) && !tick |=> !o_done)
        else $error("completion without a unit clock edge");

    a_serial_hold: assert property ( // see RULE17
        (state == PAL_ST_SERIAL) && !i_qspi_idle |=> !o_done)
        else $error("serial flash access ended while bus busy");

    a_serial_end: assert property ( // see RULE18
        (state == PAL_ST_SERIAL) && i_qspi_idle |=> o_done && o_ready)
        else $error("serial flash access not ended when bus idle");

    // Equal-clock reads pin the sum exactly: five base plus two extra.
    a_wide_uart: assert property ( // see RULE12
        take && lat.hit && (lat.idx == `PAL_I_SCI) && i_fast_eq &&
        !i_wr && (i_size == PAL_SZ_HALF) |=> (tgt == 8'h07))
        else $error("wide uart register lacks two extra cycles");

    a_wide_spi: assert property ( // see RULE13
        take && lat.hit && (lat.idx == `PAL_I_SPI) && i_fast_eq &&
        !i_wr && (i_size == PAL_SZ_WORD) &&
        (i_addr[11:0] == `PAL_SPI_DATA_OFF) |=> (tgt == 8'h07))
        else $error("spi data word lacks two extra cycles");

    a_hold_master: assert property ( // see RULE25
        (state != PAL_ST_IDLE) |-> !o_ready ##0 (o_per_sel == hit_q))
        else $error("master not held during access");

    a_done_pulse: assert property ( // see RULE25
        o_done |=> !o_done)
        else $error("done wider than one cycle");

    a_addr_stable: assert property ( // see RULE24
        (state != PAL_ST_IDLE) && ($past(state) != PAL_ST_IDLE)
        |-> $stable(o_per_addr) && $stable(o_per_wdata))
        else $error("peripheral address moved mid access");

endmodule : pal_bridge

// [tb/pal_master_model.sv]
// Bus master model: issues one access per go pulse and times it.
// Assumes the bridge answers each taken request with one done pulse.
`timescale 1ns/1ps
module pal_master_model (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_nrst,
    // Commands from the bench
    input wire logic i_go,
    input wire logic i_wr,
    input wire pal_pkg::pal_size_type i_size,
    input wire logic [31:0] i_addr,
    // Request towards the bridge
    output logic o_req,
    output logic o_wr,
    output pal_pkg::pal_size_type o_size,
    output logic [31:0] o_addr,
    output logic [31:0] o_wdata,
    // Answer from the bridge
    input wire logic i_ready,
    input wire logic i_done,
    input wire logic i_err,
    input wire logic [31:0] i_rdata,
    // Results to the bench
    output logic o_fin,
    output logic [7:0] o_lat,
    output logic [31:0] o_rdata,
    output logic o_err
);
    import pal_pkg::*;
    logic busy;
    logic [7:0] cnt;

    // Only one access is ever open, so no other master contends.
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_req <= 1'b0;
            o_wr <= 1'b0;
            o_size <= PAL_SZ_WORD;
            o_addr <= 32'h0000_0000;
            o_wdata <= 32'h0000_0000;
        end else if (i_go) begin
            o_req <= 1'b1;
            o_wr <= i_wr;
            o_size <= i_size;
            o_addr <= i_addr;
            o_wdata <= ~i_addr;
        end else if (o_req && i_ready) begin
            // Released address and data lines are scrambled so stale values cannot help.
            o_req <= 1'b0;
            o_addr <= ~o_addr;
            o_wdata <= ~o_wdata;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            busy <= 1'b0;
            cnt <= 8'h00;
            o_fin <= 1'b0;
            o_lat <= 8'h00;
            o_rdata <= 32'h0000_0000;
            o_err <= 1'b0;
        end else begin
            o_fin <= 1'b0;
            if (o_req && i_ready) begin
                busy <= 1'b1;
                cnt <= 8'h01;
            end else if (busy) begin
                cnt <= cnt + 8'h01;
            end
            if (busy && i_done) begin
                busy <= 1'b0;
                o_fin <= 1'b1;
                o_lat <= cnt;
                o_rdata <= i_rdata;
                o_err <= i_err;
            end
        end
    end
endmodule : pal_master_model

// [tb/tb.sv]
// Testbench of the access bridge: times accesses region by region.
// Assumes one divided peripheral clock shared by all three tick inputs.
`timescale 1ns/1ps
module tb;
    import pal_pkg::*;
    logic clk, nrst, go, c_wr, eqm, idle, req, wr, rdy, done, err, sel;
    logic p_wr, fin, m_err;
    // Given at declaration so the clocked process below is their only driver.
    logic tk = 1'b1;
    pal_size_type c_sz, sz, p_sz;
    logic [31:0] c_addr, addr, wdat, rd, p_addr, p_wdat, per_rd, rdat;
    logic [7:0] lat;
    logic [15:0] noise = 16'h0000;
    int miscompares = 0;
    int tests_run = 0;
    // Address, equal-clock read and write cycles.
    logic [47:0] eq_tab [16] = '{
        {32'h4000_0000, 16'h0202}, {32'h4000_8000, 16'h0403},
        {32'h4001_E000, 16'h0504}, {32'h4001_E400, 16'h0908},
        {32'h4008_0000, 16'h0504}, {32'h4008_2000, 16'h0504},
        {32'h4009_0000, 16'h0605}, {32'h4009_4000, 16'h0403},
        {32'h4009_F000, 16'h0504}, {32'h400E_8000, 16'h0704},
        {32'h4010_8000, 16'h0504}, {32'h4016_1000, 16'h0604},
        {32'h4016_9000, 16'h0704}, {32'h4017_0000, 16'h0504},
        {32'h6400_0804, 16'h0403}, {32'h407F_C000, 16'h0303}};
    // Address, read min and max, write min and max, in unit cycles.
    logic [63:0] fs_tab [9] = '{
        {32'h4001_E400, 32'h0508_0508}, {32'h4008_0000, 32'h0205_0204},
        {32'h4008_2000, 32'h0305_0204}, {32'h4009_0000, 32'h0306_0305},
        {32'h4009_4000, 32'h0104_0103}, {32'h400E_8000, 32'h0507_0204},
        {32'h4016_1000, 32'h0306_0204}, {32'h4016_9000, 32'h0407_0204},
        {32'h407F_C000, 32'h0203_0203}};

    pal_master_model mst_u (.i_core_clk(clk), .i_nrst(nrst), .i_go(go),
        .i_wr(c_wr), .i_size(c_sz), .i_addr(c_addr), .o_req(req),
        .o_wr(wr), .o_size(sz), .o_addr(addr), .o_wdata(wdat),
        .i_ready(rdy), .i_done(done), .i_err(err), .i_rdata(rd),
        .o_fin(fin), .o_lat(lat), .o_rdata(rdat), .o_err(m_err));
    pal_bridge dut_u (.i_core_clk(clk), .i_nrst(nrst), .i_req(req),
        .i_wr(wr), .i_size(sz), .i_addr(addr), .i_wdata(wdat),
        .o_ready(rdy), .o_done(done), .o_err(err), .o_rdata(rd),
        .i_fast_tick(tk), .i_slow_tick(tk), .i_flash_tick(tk),
        .i_fast_eq(eqm), .i_slow_eq(eqm), .i_flash_eq(eqm),
        .i_qspi_idle(idle), .o_per_sel(sel), .o_per_wr(p_wr),
        .o_per_size(p_sz), .o_per_addr(p_addr), .o_per_wdata(p_wdat),
        .i_per_rdata(per_rd));

    // An unselected peripheral shows a changing pattern, not old data.
    assign per_rd = sel ? (p_addr ^ 32'h5A5A_0000) : ~{noise, noise};

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        noise <= noise + 16'h0001;
        tk <= eqm ? 1'b1 : ~tk;
    end

    task automatic chk_cyc(input string nm, input logic [7:0] e, g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk_cyc
    task automatic chk_dat(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_dat
    task automatic chk_rng(input string nm, input logic [7:0] lo, hi, g);
        tests_run++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            miscompares++;
            $display("ERROR %s expected %0d to %0d seen %0d", nm, lo, hi, g);
        end
    endtask : chk_rng

    task automatic acc(input logic w, input pal_size_type s,
                       input logic [31:0] a, input int idle_at);
        int n;
        @(posedge clk);
        go <= 1'b1;
        c_wr <= w;
        c_sz <= s;
        c_addr <= a;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        while (fin !== 1'b1 && n < 300) begin
            if (n == idle_at) idle <= 1'b1;
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 300) chk_dat("access completion", 32'h1, 32'h0);
    endtask : acc

    task automatic t_reset;
        chk_dat("idle outputs", 32'h0000_0011,
                {27'h0, rdy, done, err, sel, 1'b1});
        chk_dat("reset read data", 32'h0000_0000, rd);
    endtask : t_reset

    task automatic t_equal;
        logic [47:0] e;
        eqm <= 1'b1;
        foreach (eq_tab[i]) begin
            e = eq_tab[i];
            acc(1'b0, PAL_SZ_WORD, e[47:16], -1);
            chk_cyc("read cycles", e[15:8], lat);
            chk_dat("read data", e[47:16] ^ 32'h5A5A_0000, rdat);
            chk_dat("error flag", 32'h0, {31'h0, m_err});
            acc(1'b1, PAL_SZ_WORD, e[47:16], -1);
            chk_cyc("write cycles", e[7:0], lat);
            chk_dat("write data out", ~e[47:16], p_wdat);
            chk_dat("write flag out", 32'h1, {31'h0, p_wr});
        end
    endtask : t_equal

    task automatic t_faster;
        logic [63:0] e;
        eqm <= 1'b0;
        acc(1'b0, PAL_SZ_WORD, 32'h4000_0000, -1);
        chk_cyc("core read cycles", 8'h02, lat);
        acc(1'b0, PAL_SZ_WORD, 32'h4000_8000, -1);
        chk_cyc("core read cycles", 8'h04, lat);
        foreach (fs_tab[i]) begin
            e = fs_tab[i];
            // Ticks come every second core cycle; partial units round up.
            acc(1'b0, PAL_SZ_WORD, e[63:32], -1);
            chk_rng("read units", e[31:24], e[23:16],
                    (lat + 8'h01) >> 1);
            acc(1'b1, PAL_SZ_WORD, e[63:32], -1);
            chk_rng("write units", e[15:8], e[7:0], (lat + 8'h01) >> 1);
        end
        eqm <= 1'b1;
    endtask : t_faster

    task automatic t_extra;
        acc(1'b0, PAL_SZ_HALF, 32'h4011_8000, -1);
        chk_cyc("uart half read", 8'h07, lat);
        acc(1'b1, PAL_SZ_HALF, 32'h4011_8002, -1);
        chk_cyc("uart half write", 8'h06, lat);
        acc(1'b0, PAL_SZ_BYTE, 32'h4011_8003, -1);
        chk_cyc("uart byte read", 8'h05, lat);
        acc(1'b0, PAL_SZ_WORD, 32'h4011_A004, -1);
        chk_cyc("spi word read", 8'h07, lat);
        acc(1'b0, PAL_SZ_HALF, 32'h4011_A004, -1);
        chk_cyc("spi half read", 8'h05, lat);
        chk_dat("peripheral size", 32'h1, {30'h0, p_sz});
    endtask : t_extra

    task automatic t_qspi;
        acc(1'b0, PAL_SZ_WORD, 32'h6400_0004, -1);
        chk_cyc("flash ctrl read", 8'h05, lat);
        idle <= 1'b0;
        acc(1'b1, PAL_SZ_WORD, 32'h6400_0014, 19);
        chk_rng("flash ctrl write", 8'h13, 8'h15, lat);
        acc(1'b0, PAL_SZ_WORD, 32'h6400_0010, -1);
        chk_rng("flash window read", 8'h19, 8'h1B, lat);
        acc(1'b1, PAL_SZ_WORD, 32'h6400_0010, -1);
        chk_rng("flash window write", 8'h06, 8'h08, lat);
    endtask : t_qspi

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    initial begin
        #500000;
        miscompares++;
        test_done();
    end

    initial begin
        nrst = 1'b0;
        go = 1'b0;
        c_wr = 1'b0;
        c_sz = PAL_SZ_WORD;
        c_addr = 32'h0000_0000;
        eqm = 1'b1;
        idle = 1'b1;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        t_reset();
        t_equal();
        t_faster();
        t_extra();
        t_qspi();
        test_done();
    end
endmodule : tb
